// ### rtl/paged_window_defines.vh
// Constants for the paged extended data window address block.
// Assumes it is included by its bare name from the design file.
`ifndef PAGED_WINDOW_DEFINES_VH
`define PAGED_WINDOW_DEFINES_VH

// Data space and page geometry.
`define EA_W           16
`define XA_W           24
`define EA_WIN_BIT     15
`define OFS_W          15
`define RPAGE_W        10
`define WPAGE_W        9
`define RPAGE_PV_BIT   9
`define PAGE_ZERO      9'h000
`define BASE_LO        16'h0800
`define BASE_HI        16'h7FFF
`define XRAM_TOP       24'h0187FF

// Access cycle counts (extra stall cycles beyond the first).
`define RD_EXTRA       2'h1
`define RPT_EXTRA      2'h2
`define NO_EXTRA       2'h0
`define RPT_SLOW_CNT   2'h2
`define STALL_LAST     2'h1
`define CNT_STEP       2'h1

// Avalon word indices and reset values.
`define AV_ADDR_W      2
`define DATA_W         16
`define LANE_W         8
`define LANES          2
`define IDX_RPAGE      2'h0
`define IDX_WPAGE      2'h1
`define IDX_STATUS     2'h2
`define IDX_TRAPADDR   2'h3
`define RPAGE_RST      10'h000
`define WPAGE_RST      9'h000
`define ST_TRAP_BIT    0
`define ST_BUSY_BIT    1
`define ST_RPT_LO      2
`define ST_RPT_HI      3

// Target codes.
`define TGT_NONE       2'h0
`define TGT_XRAM       2'h1
`define TGT_XPORT      2'h2
`define TGT_PVIEW      2'h3

`endif

// ### rtl/paged_data_window_addr.v
// Address generation for the paged extended data window of a 16-bit core.
// Assumes the core holds a request steady until cpu_done_o and that
// software on the Avalon port loads the page registers.
//
// The Avalon-MM interface to the registers and the address map were chosen for this implementation.
`include "paged_window_defines.vh"

module paged_data_window_addr (
	input  wire                  clock_i,          // Core clock, 125 MHz
	input  wire                  reset_i,          // Sync reset, active high
	input  wire                  ce_i,             // Clock enable
	input  wire [`AV_ADDR_W-1:0] avs_address_i,    // Avalon word index
	input  wire                  avs_read_i,       // Avalon read
	input  wire                  avs_write_i,      // Avalon write
	input  wire [31:0]           avs_writedata_i,  // Avalon write data
	input  wire [3:0]            avs_byteenable_i, // Avalon byte enables
	output wire [31:0]           avs_readdata_o,   // Avalon read data
	output wire                  avs_waitrequest_o,// Avalon wait
	input  wire                  cpu_req_i,        // Core data access
	input  wire                  cpu_we_i,         // Access is a write
	input  wire                  cpu_repeat_i,     // Inside repeat loop
	input  wire [`EA_W-1:0]      effective_addr_i, // Effective address
	output wire                  cpu_done_o,       // Access completes
	output wire [`XA_W-1:0]      ext_addr_o,       // 24-bit address
	output wire                  base_sel_o,       // Base data memory
	output wire                  ext_ram_sel_o,    // Extended RAM
	output wire                  ext_port_sel_o,   // External port
	output wire                  pgm_view_sel_o,   // Program view path
	output wire                  addr_error_o      // Trap pulse
);

	localparam ST_IDLE  = 1'b0;
	localparam ST_STALL = 1'b1;

	// Picks the paged target for a translated address.
	function [1:0] target_of;
		input [`XA_W-1:0] xa;
		begin
			if (xa <= `XRAM_TOP) begin
				target_of = `TGT_XRAM;
			end else begin
				target_of = `TGT_XPORT;
			end
		end
	endfunction

	// Joins a 9-bit page above the in-page offset.
	function [`XA_W-1:0] join_page;
		input [`WPAGE_W-1:0] page;
		input [`EA_W-1:0]    ea;
		begin
			join_page = {page, ea[`OFS_W-1:0]};
		end
	endfunction

	// Decodes a completed Avalon write to one register index.
	function wr_hit;
		input                  go;
		input [`AV_ADDR_W-1:0] idx;
		input [`AV_ADDR_W-1:0] want;
		begin
			wr_hit = go & (idx == want);
		end
	endfunction

	// Merges the enabled byte lanes of fresh data over an old value.
	function [`DATA_W-1:0] merge_lanes;
		input [`DATA_W-1:0] old;
		input [`DATA_W-1:0] fresh;
		input [`DATA_W-1:0] mask;
		begin
			merge_lanes = (old & ~mask) | (fresh & mask);
		end
	endfunction

	reg  [`RPAGE_W-1:0] read_page_select_ff;
	reg  [`WPAGE_W-1:0] write_page_select_ff;
	reg                 trap_seen_ff;
	reg  [`XA_W-1:0]    trap_addr_ff;
	reg                 state_ff;
	reg  [1:0]          stall_cnt_ff;
	reg  [1:0]          rpt_cnt_ff;
	reg                 addr_error_ff;
	reg                 av_ack_ff;
	reg  [31:0]         av_rdata_ff;

	reg                 nxt_state;
	reg  [1:0]          nxt_stall_cnt;
	reg  [1:0]          nxt_rpt_cnt;
	reg  [1:0]          extra;
	reg  [31:0]         rd_mux;

	wire                window;
	wire                pv_read;
	wire [`WPAGE_W-1:0] page;
	wire                page_zero;
	wire                trap;
	wire                win_read;
	wire [`XA_W-1:0]    xaddr;
	wire [1:0]          tgt;
	wire                base_hit;
	wire                av_req;
	wire                av_wr_go;
	wire [`DATA_W-1:0]  wmask;
	wire [`DATA_W-1:0]  wdata;
	wire [`DATA_W-1:0]  rpage_merged;
	wire [`DATA_W-1:0]  wpage_merged;
	wire                wr_rpage;
	wire                wr_wpage;
	wire                wr_status;
	wire                trap_hit;
	wire                stall_last;
	genvar              lane;

	// The window opens only on pointer bit 15; below it pages are ignored.
	assign window  = effective_addr_i[`EA_WIN_BIT];
	assign pv_read = window & ~cpu_we_i
		& read_page_select_ff[`RPAGE_PV_BIT];
	assign page    = cpu_we_i ? write_page_select_ff
		: read_page_select_ff[`WPAGE_W-1:0];
	assign page_zero = (page == `PAGE_ZERO);
	// Program view reads carry their own page meaning, so no trap there.
	assign trap     = cpu_req_i & window & ~pv_read & page_zero;
	assign win_read = window & ~cpu_we_i;

	// Read uses the read page, write the write page.
	assign xaddr = window ? join_page(page, effective_addr_i)
		: {{(`XA_W-`EA_W){1'b0}}, effective_addr_i};
	assign tgt = target_of(xaddr);
	assign base_hit = ~window & (effective_addr_i >= `BASE_LO)
		& (effective_addr_i <= `BASE_HI);

	assign ext_addr_o     = xaddr;
	assign base_sel_o     = cpu_req_i & base_hit;
	assign ext_ram_sel_o  = cpu_req_i & window & ~pv_read & ~page_zero
		& (tgt == `TGT_XRAM);
	assign ext_port_sel_o = cpu_req_i & window & ~pv_read & ~page_zero
		& (tgt == `TGT_XPORT);
	assign pgm_view_sel_o = cpu_req_i & pv_read;
	assign addr_error_o   = addr_error_ff;

	// Stall cycles for the access now offered.
	always @* begin
		if (trap | ~win_read) begin
			extra = `NO_EXTRA;
		end else if (cpu_repeat_i) begin
			if (rpt_cnt_ff < `RPT_SLOW_CNT) begin
				extra = `RPT_EXTRA;
			end else begin
				extra = `NO_EXTRA;
			end
		end else begin
			extra = `RD_EXTRA;
		end
	end

	assign stall_last = (stall_cnt_ff == `STALL_LAST);
	assign cpu_done_o = cpu_req_i & (((state_ff == ST_IDLE)
		& (extra == `NO_EXTRA))
		| ((state_ff == ST_STALL) & stall_last));
	assign trap_hit   = trap & cpu_done_o;

	always @* begin
		nxt_state     = state_ff;
		nxt_stall_cnt = stall_cnt_ff;
		nxt_rpt_cnt   = rpt_cnt_ff;
		case (state_ff)
			ST_IDLE: begin
				if (cpu_req_i & (extra != `NO_EXTRA)) begin
					nxt_state     = ST_STALL;
					nxt_stall_cnt = extra;
				end
			end
			ST_STALL: begin
				nxt_stall_cnt = stall_cnt_ff - `CNT_STEP;
				if (stall_last) begin
					nxt_state = ST_IDLE;
				end
			end
			default: begin
				nxt_state     = ST_IDLE;
				nxt_stall_cnt = 2'h0;
			end
		endcase
		// The repeat count saturates; leaving the loop restarts it.
		if (~cpu_repeat_i) begin
			nxt_rpt_cnt = 2'h0;
		end else if (cpu_done_o & win_read & ~trap
			& (rpt_cnt_ff < `RPT_SLOW_CNT)) begin
			nxt_rpt_cnt = rpt_cnt_ff + `CNT_STEP;
		end
	end

	always @(posedge clock_i) begin
		if (reset_i) begin
			state_ff      <= ST_IDLE;
			stall_cnt_ff  <= 2'h0;
			rpt_cnt_ff    <= 2'h0;
			addr_error_ff <= 1'b0;
		end else if (ce_i) begin
			state_ff      <= nxt_state;
			stall_cnt_ff  <= nxt_stall_cnt;
			rpt_cnt_ff    <= nxt_rpt_cnt;
			addr_error_ff <= trap_hit;
		end
	end

	// Avalon slave: every access waits exactly one cycle, which gives
	// the read data a flop stage without a combinational path.
	assign av_req   = avs_read_i | avs_write_i;
	assign av_wr_go = avs_write_i & av_ack_ff;
	assign avs_waitrequest_o = av_req & ~av_ack_ff;
	assign avs_readdata_o    = av_rdata_ff;
	assign wdata     = avs_writedata_i[`DATA_W-1:0];
	assign wr_rpage  = wr_hit(av_wr_go, avs_address_i, `IDX_RPAGE);
	assign wr_wpage  = wr_hit(av_wr_go, avs_address_i, `IDX_WPAGE);
	assign wr_status = wr_hit(av_wr_go, avs_address_i, `IDX_STATUS);

	// Only the two low byte lanes hold writable register bits.
	generate
		for (lane = 0; lane < `LANES; lane = lane + 1) begin : g_lane
			assign wmask[lane*`LANE_W +: `LANE_W] =
				{`LANE_W{avs_byteenable_i[lane]}};
		end
	endgenerate

	assign rpage_merged = merge_lanes({{(`DATA_W-`RPAGE_W){1'b0}},
		read_page_select_ff}, wdata, wmask);
	assign wpage_merged = merge_lanes({{(`DATA_W-`WPAGE_W){1'b0}},
		write_page_select_ff}, wdata, wmask);

	always @* begin
		rd_mux = 32'h0000_0000;
		case (avs_address_i)
			`IDX_RPAGE: begin
				rd_mux[`RPAGE_W-1:0] = read_page_select_ff;
			end
			`IDX_WPAGE: begin
				rd_mux[`WPAGE_W-1:0] = write_page_select_ff;
			end
			`IDX_STATUS: begin
				rd_mux[`ST_TRAP_BIT] = trap_seen_ff;
				rd_mux[`ST_BUSY_BIT] = (state_ff == ST_STALL);
				rd_mux[`ST_RPT_HI:`ST_RPT_LO] = rpt_cnt_ff;
			end
			`IDX_TRAPADDR: begin
				rd_mux[`XA_W-1:0] = trap_addr_ff;
			end
			default: begin
				rd_mux = 32'h0000_0000;
			end
		endcase
	end

	always @(posedge clock_i) begin
		if (reset_i) begin
			av_ack_ff   <= 1'b0;
			av_rdata_ff <= 32'h0000_0000;
		end else if (ce_i) begin
			av_ack_ff <= av_req & ~av_ack_ff;
			if (avs_read_i & ~av_ack_ff) begin
				av_rdata_ff <= rd_mux;
			end
		end
	end

	// Pages never step on their own at 0xFFFF; software does it.
	always @(posedge clock_i) begin
		if (reset_i) begin
			read_page_select_ff  <= `RPAGE_RST;
			write_page_select_ff <= `WPAGE_RST;
		end else if (ce_i) begin
			if (wr_rpage) begin
				read_page_select_ff <= rpage_merged[`RPAGE_W-1:0];
			end
			if (wr_wpage) begin
				write_page_select_ff <= wpage_merged[`WPAGE_W-1:0];
			end
		end
	end

	// A new trap wins over a write-one clear in the same cycle.
	always @(posedge clock_i) begin
		if (reset_i) begin
			trap_seen_ff <= 1'b0;
			trap_addr_ff <= {`XA_W{1'b0}};
		end else if (ce_i) begin
			if (trap_hit) begin
				trap_seen_ff <= 1'b1;
				trap_addr_ff <= xaddr;
			end else if (wr_status & avs_byteenable_i[0]
				& wdata[`ST_TRAP_BIT]) begin
				trap_seen_ff <= 1'b0;
			end
		end
	end

endmodule // paged_data_window_addr

// ### bench/core_model.sv
// Core load/store model: raises one data request and holds it until done.
// Assumes the bench pulses start_i for one cycle while req_o is low.
module core_model (
	input  wire         clock_i, // Core clock
	input  wire         reset_i, // Sync reset, active high
	input  wire         start_i, // Begin one access
	input  wire         we_i,    // Access is a write
	input  wire  [15:0] ea_i,    // Pointer, bit 15 opens the window
	input  wire         done_i,  // Block completes the access
	output logic        req_o,   // Request to the block
	output logic        we_o,    // Direction to the block
	output logic [15:0] ea_o,    // Pointer to the block
	output logic [2:0]  cyc_o    // Cycles the last access took
);
	always @(posedge clock_i) begin
		if (reset_i) begin
			req_o <= 1'b0;
			we_o <= 1'b0;
			ea_o <= 16'h0;
			cyc_o <= 3'h0;
		end else if (!req_o && start_i) begin
			req_o <= 1'b1;
			we_o <= we_i;
			ea_o <= ea_i;
			cyc_o <= 3'h1;
		end else if (req_o && done_i) begin
			req_o <= 1'b0;
			// A released pointer must not look valid, so it is inverted.
			ea_o <= ~ea_o;
		end else if (req_o) begin
			cyc_o <= cyc_o + 3'h1;
		end
	end
endmodule // core_model

// ### bench/data_window_monitor.sv
// Checker for the paged window address block.
// Bound into the block; it watches the block's ports only.
module data_window_monitor (
	input wire        clock_i,           // Clock
	input wire        reset_i,           // Reset
	input wire        avs_read_i,        // Read
	input wire        avs_write_i,       // Write
	input wire        avs_waitrequest_o, // Wait
	input wire        cpu_req_i,         // Request
	input wire        cpu_we_i,          // Write
	input wire        cpu_repeat_i,      // Repeat
	input wire [15:0] effective_addr_i,  // Pointer
	input wire        cpu_done_o,        // Done
	input wire [23:0] ext_addr_o,        // Address
	input wire        base_sel_o,        // Base
	input wire        ext_ram_sel_o,     // RAM
	input wire        ext_port_sel_o,    // Port
	input wire        pgm_view_sel_o,    // View
	input wire        addr_error_o       // Trap
);
	wire [15:0] ea = effective_addr_i;
	wire win = cpu_req_i && ea[15];
	wire sel = ext_ram_sel_o || ext_port_sel_o || pgm_view_sel_o;
	default clocking @(posedge clock_i); endclocking
	default disable iff (reset_i);
	chk_low_addr: assert property (cpu_req_i && !ea[15] |->
		ext_addr_o == {8'h00, ea}) else $error("low address wrong");
	chk_base_sel: assert property (cpu_req_i |->
		base_sel_o == (!ea[15] && ea >= 16'h0800)) else $error("base");
	chk_win_offset: assert property (win |->
		ext_addr_o[14:0] == ea[14:0]) else $error("offset wrong");
	chk_ram_top: assert property (ext_ram_sel_o |->
		ext_addr_o <= 24'h0187FF && !ext_port_sel_o) else $error("ram");
	chk_view_read: assert property (pgm_view_sel_o |->
		!cpu_we_i && !ext_ram_sel_o && !ext_port_sel_o) else $error("view");
	chk_write_once: assert property (win && cpu_we_i |->
		cpu_done_o) else $error("write stalled");
	chk_read_stall: assert property ($rose(cpu_req_i) && !cpu_we_i &&
		!cpu_repeat_i && sel |-> !cpu_done_o ##1 cpu_done_o)
		else $error("read timing");
	chk_trap_now: assert property (win && !sel |->
		cpu_done_o ##1 addr_error_o) else $error("trap missing");
	chk_trap_cause: assert property (addr_error_o |->
		$past(win && !sel && cpu_done_o)) else $error("stray trap");
	chk_av_wait: assert property ($rose(avs_read_i || avs_write_i) |->
		avs_waitrequest_o ##1 !avs_waitrequest_o) else $error("wait");
endmodule // data_window_monitor
bind paged_data_window_addr data_window_monitor data_window_monitor_i (.*);

// ### bench/paged_data_window_addr_test.sv
// Self-checking bench for the paged window address block.
// Drives the core side through core_model, registers over Avalon.
`include "paged_window_defines.vh"
`define CHK(a, e) begin checks++; if ((a) !== (e)) begin failures++; \
	$display("unexpected at %0t: %h %h", $time, (a), (e)); end end
module paged_data_window_addr_test;
	timeunit 1ns;
	timeprecision 1ps;
	typedef struct packed {
		logic we; logic [9:0] rp; logic [8:0] wp; logic [15:0] ea;
		logic [23:0] xa; logic [3:0] sel; logic [2:0] cyc; logic err;
	} row_t;
	row_t rows [0:8] = '{
		'{1'b0,10'h002,9'h000,16'h8800,24'h010800,4'h4,3'h2,1'b0},
		'{1'b1,10'h000,9'h003,16'h87FE,24'h0187FE,4'h4,3'h1,1'b0},
		'{1'b1,10'h000,9'h004,16'h8000,24'h020000,4'h2,3'h1,1'b0},
		'{1'b0,10'h005,9'h000,16'hFFFF,24'h02FFFF,4'h2,3'h2,1'b0},
		'{1'b0,10'h000,9'h007,16'h9000,24'h001000,4'h0,3'h1,1'b1},
		'{1'b1,10'h007,9'h000,16'h8000,24'h000000,4'h0,3'h1,1'b1},
		'{1'b0,10'h000,9'h000,16'h0800,24'h000800,4'h8,3'h1,1'b0},
		'{1'b0,10'h000,9'h000,16'h0400,24'h000400,4'h0,3'h1,1'b0},
		'{1'b0,10'h201,9'h000,16'h8010,24'h008010,4'h1,3'h2,1'b0}};
	logic [2:0]  rep [0:2] = '{3'h3, 3'h3, 3'h1};
	logic        clock_i = 1'b0;
	logic        reset_i = 1'b1;
	logic [1:0]  avs_address_i = 2'h0;
	logic        avs_read_i = 1'b0;
	logic        avs_write_i = 1'b0;
	logic [31:0] avs_writedata_i = 32'h0;
	logic        cpu_repeat_i = 1'b0;
	logic        start = 1'b0;
	logic        we = 1'b0;
	logic [15:0] ea = 16'h0;
	wire  [31:0] avs_readdata_o;
	wire  [15:0] effective_addr_i;
	wire  [23:0] ext_addr_o;
	wire  [2:0]  cyc;
	wire         avs_waitrequest_o, cpu_req_i, cpu_we_i, cpu_done_o;
	wire         base_sel_o, ext_ram_sel_o, ext_port_sel_o;
	wire         pgm_view_sel_o, addr_error_o;
	logic [31:0] rd;
	logic [23:0] xa;
	logic [3:0]  sel;
	integer      failures = 0;
	integer      checks = 0;
	paged_data_window_addr paged_data_window_addr_i (.*, .ce_i(1'b1),
		.avs_byteenable_i(4'hF));
	core_model core_model_i (.clock_i(clock_i), .reset_i(reset_i),
		.start_i(start), .we_i(we), .ea_i(ea), .done_i(cpu_done_o),
		.req_o(cpu_req_i), .we_o(cpu_we_i), .ea_o(effective_addr_i),
		.cyc_o(cyc));
	initial forever #4 clock_i = ~clock_i;
	task report_and_stop;
		begin
			$display("checks %0d failures %0d", checks, failures);
			if (failures == 0 && checks > 0)
				$display("DONE - PASS");
			else
				$display("DONE - FAIL");
			$finish;
		end
	endtask
	task av(input logic w, input logic [1:0] a, input logic [31:0] d);
		integer n;
		begin
			@(posedge clock_i);
			avs_write_i <= w;
			avs_read_i <= !w;
			avs_address_i <= a;
			avs_writedata_i <= d;
			n = 0;
			do begin
				@(posedge clock_i);
				n++;
			end while (avs_waitrequest_o !== 1'b0 && n < 20);
			rd = avs_readdata_o;
			avs_write_i <= 1'b0;
			avs_read_i <= 1'b0;
			if (n >= 20) begin
				failures++;
				report_and_stop;
			end
		end
	endtask
	task access(input logic w, input logic [15:0] a);
		integer n;
		begin
			@(posedge clock_i);
			start <= 1'b1;
			we <= w;
			ea <= a;
			@(posedge clock_i);
			start <= 1'b0;
			#1;
			xa = ext_addr_o;
			sel = {base_sel_o, ext_ram_sel_o, ext_port_sel_o, pgm_view_sel_o};
			// The trap pulse lands just after the done edge, seen on exit.
			for (n = 0; cpu_req_i && n < 20; n++) begin
				@(posedge clock_i);
				#1;
			end
			if (n >= 20) begin
				failures++;
				report_and_stop;
			end
		end
	endtask
	initial begin
		repeat (8) @(posedge clock_i);
		reset_i <= 1'b0;
		av(1'b0, `IDX_RPAGE, 32'h0);
		`CHK(rd, {22'h0, `RPAGE_RST})
		av(1'b1, `IDX_WPAGE, 32'hFFFF);
		av(1'b0, `IDX_WPAGE, 32'h0);
		`CHK(rd, 32'h1FF)
		foreach (rows[i]) begin
			av(1'b1, `IDX_RPAGE, {22'h0, rows[i].rp});
			av(1'b1, `IDX_WPAGE, {23'h0, rows[i].wp});
			access(rows[i].we, rows[i].ea);
			`CHK(xa, rows[i].xa)
			`CHK(sel, rows[i].sel)
			`CHK(cyc, rows[i].cyc)
			`CHK(addr_error_o, rows[i].err)
		end
		// A page-zero window read must leave its address in the trap word.
		av(1'b1, `IDX_RPAGE, 32'h0);
		access(1'b0, 16'hABCD);
		`CHK(addr_error_o, 1'b1)
		av(1'b0, `IDX_TRAPADDR, 32'h0);
		`CHK(rd, 32'h0000_2BCD)
		av(1'b1, `IDX_RPAGE, 32'h2);
		cpu_repeat_i <= 1'b1;
		foreach (rep[k]) begin
			access(1'b0, 16'h8000);
			`CHK(cyc, rep[k])
		end
		// Status holds the sticky trap flag and the saturated repeat count.
		av(1'b0, `IDX_STATUS, 32'h0);
		`CHK(rd, 32'h0000_0009)
		av(1'b1, `IDX_STATUS, 32'h1);
		av(1'b0, `IDX_STATUS, 32'h0);
		`CHK(rd, 32'h0000_0008)
		cpu_repeat_i <= 1'b0;
		// Reset in mid-run: pages return to zero, so the window traps.
		av(1'b1, `IDX_WPAGE, 32'h5);
		reset_i <= 1'b1;
		repeat (2) @(posedge clock_i);
		reset_i <= 1'b0;
		av(1'b0, `IDX_WPAGE, 32'h0);
		`CHK(rd, {23'h0, `WPAGE_RST})
		av(1'b0, `IDX_STATUS, 32'h0);
		`CHK(rd, 32'h0000_0000)
		access(1'b1, 16'h8000);
		`CHK(addr_error_o, 1'b1)
		report_and_stop;
	end
endmodule // paged_data_window_addr_test
